// File: hdl/ssf_status.v
`timescale 1ns/10ps
`include "ssf_defs.vh"

module ssf_status (
    input wire clock,
    input wire resetn,
    input wire standby,
    input wire [3:0] address,
    input wire [7:0] write_data,
    input wire write_strobe,
    input wire read_strobe,
    output reg [7:0] read_data,
    input wire tx_load,
    input wire tx_last_bit,
    input wire xfer_tx_write,
    input wire rx_done,
    input wire rx_stop_bit,
    input wire rx_parity_ok,
    input wire rx_mp_bit_in,
    input wire xfer_rx_read,
    output wire transmitter_enable,
    output wire receiver_enable,
    output wire tx_multiproc_bit,
    output wire tx_empty_request,
    output wire rx_full_request,
    output wire tx_end_request
);
    // ****************************************
    // Reset synchroniser
    // ****************************************
    reg [1:0] reset_sync;
    wire reset;

    always @(posedge clock or negedge resetn) begin
        if (!resetn)
            reset_sync <= 2'b00;
        else
            reset_sync <= {reset_sync[0], 1'b1};
    end
    assign reset = ~reset_sync[1];

    // ****************************************
    // Register access decode
    // ****************************************
    wire status_write;
    wire status_read;
    wire [7:0] status;
    reg [7:0] control;
    reg tx_mp_bit;
    reg rx_mp_bit;
    reg transmit_end;
    wire tx_holding_empty;
    wire rx_holding_full;
    wire overrun_error;
    wire framing_error;
    wire parity_error;

    assign status_write = write_strobe && (address == `SSF_ADDR_STATUS);
    assign status_read = read_strobe && (address == `SSF_ADDR_STATUS);
    assign transmitter_enable = control[`SSF_BIT_TX_ENABLE];
    assign receiver_enable = control[`SSF_BIT_RX_ENABLE];

    function clear_req;
        input integer pos;
        input [7:0] data;
        input wr;
        begin
            clear_req = wr && !data[pos];
        end
    endfunction

    // ****************************************
    // Receive events
    // ****************************************
    wire rx_event;
    wire rx_overrun;
    wire rx_framing;
    wire rx_parity;
    wire rx_clean;

    assign rx_event = rx_done && receiver_enable;
    assign rx_overrun = rx_event && rx_holding_full;
    assign rx_framing = rx_event && !rx_overrun && !rx_stop_bit;
    assign rx_parity = rx_event && !rx_overrun && !rx_parity_ok;
    assign rx_clean = rx_event && !rx_overrun && rx_stop_bit && rx_parity_ok;

    // ****************************************
    // Clearable flags
    // ****************************************
    wire empty_sw_clear;
    wire empty_set;

    // set by transmitter off or load
    assign empty_set = !transmitter_enable || tx_load;
    ssf_flag #(.RESET_VALUE(1'b1)) u_tx_empty (
        .clock(clock),
        .reset(reset),
        .standby(standby),
        .set(empty_set),
        .hw_clear(xfer_tx_write),
        .read_seen(status_read),
        .write_zero(clear_req(`SSF_BIT_TX_EMPTY, write_data, status_write)),
        .flag(tx_holding_empty)
    );

    ssf_flag #(.RESET_VALUE(1'b0)) u_rx_full (
        .clock(clock),
        .reset(reset),
        .standby(standby),
        .set(rx_clean),
        .hw_clear(xfer_rx_read),
        .read_seen(status_read),
        .write_zero(clear_req(`SSF_BIT_RX_FULL, write_data, status_write)),
        .flag(rx_holding_full)
    );

    ssf_flag #(.RESET_VALUE(1'b0)) u_overrun (
        .clock(clock),
        .reset(reset),
        .standby(standby),
        .set(rx_overrun),
        .hw_clear(1'b0),
        .read_seen(status_read),
        .write_zero(clear_req(`SSF_BIT_OVERRUN, write_data, status_write)),
        .flag(overrun_error)
    );

    ssf_flag #(.RESET_VALUE(1'b0)) u_framing (
        .clock(clock),
        .reset(reset),
        .standby(standby),
        .set(rx_framing),
        .hw_clear(1'b0),
        .read_seen(status_read),
        .write_zero(clear_req(`SSF_BIT_FRAMING, write_data, status_write)),
        .flag(framing_error)
    );

    ssf_flag #(.RESET_VALUE(1'b0)) u_parity (
        .clock(clock),
        .reset(reset),
        .standby(standby),
        .set(rx_parity),
        .hw_clear(1'b0),
        .read_seen(status_read),
        .write_zero(clear_req(`SSF_BIT_PARITY, write_data, status_write)),
        .flag(parity_error)
    );

    // ****************************************
    // Transmit end tracking
    // ****************************************
    reg empty_armed;
    wire end_set;

    // Shadow of the holding-empty read arming, dropped on any set
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            empty_armed <= 1'b0;
        end else if (standby || empty_sw_clear || xfer_tx_write
            || empty_set) begin
            empty_armed <= 1'b0;
        end else if (status_read && tx_holding_empty) begin
            empty_armed <= 1'b1;
        end
    end
    assign empty_sw_clear = empty_armed
        && clear_req(`SSF_BIT_TX_EMPTY, write_data, status_write);

    // set on transmitter off or last bit with holding register empty
    assign end_set = !transmitter_enable
        || (tx_last_bit && tx_holding_empty);

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            transmit_end <= 1'b1;
        end else if (standby || end_set) begin
            transmit_end <= 1'b1;
        end else if (empty_sw_clear || xfer_tx_write) begin
            transmit_end <= 1'b0;
        end
    end

    // ****************************************
    // Multiprocessor bits and control
    // ****************************************
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            rx_mp_bit <= 1'b0;
            tx_mp_bit <= 1'b0;
            control <= `SSF_CONTROL_RESET;
        end else if (standby) begin
            rx_mp_bit <= 1'b0;
            tx_mp_bit <= 1'b0;
            control <= `SSF_CONTROL_RESET;
        end else begin
            if (rx_event)
                rx_mp_bit <= rx_mp_bit_in;
            if (status_write)
                tx_mp_bit <= write_data[`SSF_BIT_TX_MP];
            if (write_strobe && address == `SSF_ADDR_CONTROL)
                control <= write_data;
        end
    end

    assign tx_multiproc_bit = tx_mp_bit;
    assign tx_empty_request = tx_holding_empty && transmitter_enable;
    assign rx_full_request = rx_holding_full && receiver_enable;
    assign tx_end_request = transmit_end && control[`SSF_BIT_TX_END_IE];

    // ****************************************
    // Read data
    // ****************************************
    assign status = {tx_holding_empty, rx_holding_full, overrun_error,
        framing_error, parity_error, transmit_end, rx_mp_bit, tx_mp_bit};

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            read_data <= 8'h00;
        end else if (read_strobe) begin
            case (address)
                `SSF_ADDR_STATUS: read_data <= status;
                `SSF_ADDR_CONTROL: read_data <= {5'h00, control[2:0]};
                default: read_data <= 8'h00;
            endcase
        end else begin
            read_data <= 8'h00;
        end
    end
endmodule // ssf_status

// File: hdl/ssf_defs.vh
`ifndef SSF_DEFS_VH
`define SSF_DEFS_VH
// Register offsets
`define SSF_ADDR_STATUS 4'h0
`define SSF_ADDR_CONTROL 4'h1
// Status bit positions
`define SSF_BIT_TX_EMPTY 7
`define SSF_BIT_RX_FULL 6
`define SSF_BIT_OVERRUN 5
`define SSF_BIT_FRAMING 4
`define SSF_BIT_PARITY 3
`define SSF_BIT_TX_END 2
`define SSF_BIT_RX_MP 1
`define SSF_BIT_TX_MP 0
// Control bit positions
`define SSF_BIT_TX_ENABLE 0
`define SSF_BIT_RX_ENABLE 1
`define SSF_BIT_TX_END_IE 2
// Reset values
`define SSF_STATUS_RESET 8'h84
`define SSF_CONTROL_RESET 8'h00
`endif

// File: hdl/ssf_flag.v
`timescale 1ns/10ps
`include "ssf_defs.vh"

// ****************************************
// Clearable flag with read-one-then-write-zero
// ****************************************
module ssf_flag #(
    parameter RESET_VALUE = 1'b0
) (
    input wire clock,
    input wire reset,
    input wire standby,
    input wire set,
    input wire hw_clear,
    input wire read_seen,
    input wire write_zero,
    output reg flag
);
    reg armed;
    wire sw_clear;

    assign sw_clear = write_zero && armed;

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            flag <= RESET_VALUE;
            armed <= 1'b0;
        end else if (standby) begin
            flag <= RESET_VALUE;
            armed <= 1'b0;
        end else begin
            // Set wins over any clear
            if (set)
                flag <= 1'b1;
            else if (sw_clear || hw_clear)
                flag <= 1'b0;
            if (set || sw_clear || hw_clear)
                armed <= 1'b0;
            else if (read_seen && flag)
                armed <= 1'b1;
        end
    end
endmodule // ssf_flag

// File: bench/ssf_chk_sva.sv
`timescale 1ns/10ps
module ssf_chk (
    input wire clock,
    input wire resetn,
    input wire standby,
    input wire [3:0] address,
    input wire [7:0] write_data,
    input wire write_strobe,
    input wire read_strobe,
    input wire [7:0] read_data,
    input wire tx_load,
    input wire xfer_tx_write,
    input wire rx_done,
    input wire rx_stop_bit,
    input wire rx_parity_ok,
    input wire xfer_rx_read,
    input wire transmitter_enable,
    input wire receiver_enable,
    input wire tx_multiproc_bit,
    input wire tx_empty_request,
    input wire rx_full_request,
    input wire tx_end_request
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // ****
    // Flag checks
    // ****
    sequence s_quiet;
        !write_strobe && !standby;
    endsequence
    sequence s_rx_ok;
        rx_done && receiver_enable && rx_stop_bit && rx_parity_ok;
    endsequence
    a_load_sets_empty: assert property (
        tx_load && transmitter_enable ##0 s_quiet |=> tx_empty_request)
        else $error("empty not set");
    a_xfer_clears_empty: assert property (
        xfer_tx_write && !tx_load && transmitter_enable ##0 s_quiet
        |=> !tx_empty_request) else $error("empty not cleared");
    a_rx_sets_full: assert property (
        s_rx_ok ##0 (s_quiet and !xfer_rx_read) |=> rx_full_request)
        else $error("full not set");
    a_xfer_clears_full: assert property (
        xfer_rx_read && !rx_done && receiver_enable ##0 s_quiet
        |=> !rx_full_request) else $error("full not cleared");
    a_tx_bit_written: assert property (
        write_strobe && address == 4'h0 && !standby
        |=> tx_multiproc_bit == $past(write_data[0]))
        else $error("tx multiprocessor bit wrong");
    a_end_irq_gate: assert property (
        write_strobe && address == 4'h1 && !write_data[2]
        |=> !tx_end_request) else $error("end request leaked");
    a_tx_off_flags: assert property (
        !transmitter_enable ##1 (!transmitter_enable && read_strobe
        && address == 4'h0) |=> read_data[7] && read_data[2])
        else $error("flags not held");
    a_standby_clears: assert property (
        standby |=> !transmitter_enable && !rx_full_request
        && !tx_end_request) else $error("standby ignored");
endmodule // ssf_chk
bind ssf_status ssf_chk chk_u (.*);

// File: bench/ssf_station.sv
`timescale 1ns/10ps
module ssf_station (
    input wire clock,
    output reg tx_load = 1'b0,
    output reg tx_last_bit = 1'b0,
    output reg rx_done = 1'b0,
    output reg rx_stop_bit = 1'b0,
    output reg rx_parity_ok = 1'b0,
    output reg rx_mp_bit_in = 1'b0
);
    // ****
    // Line events
    // ****
    task tx_event(input last);
        begin
            @(posedge clock);
            tx_load <= !last;
            tx_last_bit <= last;
            @(posedge clock);
            tx_load <= 1'b0;
            tx_last_bit <= 1'b0;
        end
    endtask
    // Qualifiers flip once the frame is over
    task receive(input stop, input par, input mp_bit);
        begin
            @(posedge clock);
            rx_done <= 1'b1;
            rx_stop_bit <= stop;
            rx_parity_ok <= par;
            rx_mp_bit_in <= mp_bit;
            @(posedge clock);
            rx_done <= 1'b0;
            rx_stop_bit <= !stop;
            rx_parity_ok <= !par;
            rx_mp_bit_in <= !mp_bit;
        end
    endtask
endmodule // ssf_station

// File: bench/serial_status_flags_bench.sv
`timescale 1ns/10ps
module serial_status_flags_bench;
    reg clock = 1'b0;
    reg resetn = 1'b0;
    reg standby = 1'b0;
    reg [3:0] address = 4'h0;
    reg [7:0] write_data = 8'h00;
    reg write_strobe = 1'b0;
    reg read_strobe = 1'b0;
    reg xfer_tx_write = 1'b0;
    reg xfer_rx_read = 1'b0;
    wire [7:0] read_data;
    wire tx_load, tx_last_bit, rx_done, rx_stop_bit, rx_parity_ok;
    wire rx_mp_bit_in;
    wire transmitter_enable, receiver_enable, tx_multiproc_bit;
    wire tx_empty_request, rx_full_request, tx_end_request;
    integer miscompares = 0;
    integer cmp_count = 0;
    integer cycles = 0;
    always #5 clock = ~clock;
    ssf_status dut_u (.*);
    ssf_station station_u (.*);
    // ****
    // Access tasks
    // ****
    task check(input [7:0] seen, input [7:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("ERROR %0t saw %h not %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge clock);
            address <= a;
            write_data <= d;
            write_strobe <= 1'b1;
            @(posedge clock);
            write_strobe <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [7:0] exp);
        begin
            @(posedge clock);
            address <= a;
            read_strobe <= 1'b1;
            @(posedge clock);
            read_strobe <= 1'b0;
            #1 check(read_data, exp);
        end
    endtask
    task xfer(input rx);
        begin
            @(posedge clock);
            xfer_tx_write <= !rx;
            xfer_rx_read <= rx;
            @(posedge clock);
            xfer_tx_write <= 1'b0;
            xfer_rx_read <= 1'b0;
        end
    endtask
    task complete_run;
        begin
            $display("%0d compares, %0d mismatches", cmp_count, miscompares);
            if (miscompares == 0 && cmp_count > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 1000) begin
            miscompares = miscompares + 1;
            complete_run;
        end
    end
    initial begin
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        rd(4'h0, 8'h84);
        rd(4'h5, 8'h00);
        wr(4'h1, 8'h05);
        rd(4'h0, 8'h84);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h00);
        station_u.tx_event(1'b0);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h80);
        check(tx_empty_request, 1'b1);
        check(transmitter_enable, 1'b1);
        station_u.tx_event(1'b1);
        rd(4'h0, 8'h84);
        check(tx_end_request, 1'b1);
        wr(4'h0, 8'hff);
        rd(4'h0, 8'h85);
        check(tx_multiproc_bit, 1'b1);
        xfer(1'b0);
        rd(4'h0, 8'h01);
        $display("transmit test done");
        wr(4'h1, 8'h02);
        station_u.receive(1'b1, 1'b1, 1'b1);
        rd(4'h0, 8'hc7);
        check(rx_full_request, 1'b1);
        check(receiver_enable, 1'b1);
        check(tx_empty_request, 1'b0);
        station_u.receive(1'b1, 1'b1, 1'b1);
        wr(4'h1, 8'h00);
        rd(4'h0, 8'he7);
        wr(4'h1, 8'h02);
        wr(4'h0, 8'h01);
        rd(4'h0, 8'h87);
        station_u.receive(1'b0, 1'b0, 1'b1);
        rd(4'h0, 8'h9f);
        wr(4'h0, 8'h01);
        rd(4'h0, 8'h87);
        station_u.receive(1'b1, 1'b1, 1'b1);
        xfer(1'b1);
        rd(4'h0, 8'h87);
        $display("receive test done");
        @(posedge clock);
        standby <= 1'b1;
        @(posedge clock);
        standby <= 1'b0;
        rd(4'h0, 8'h84);
        rd(4'h1, 8'h00);
        $display("standby test done");
        complete_run;
    end
endmodule // serial_status_flags_bench
